/* itr_pkg.sv */
// Shared constants, register indices and state encoding for the telemetry register reader
package itr_pkg;

	// ----------------------------------------------------------------
	// Target address
	// ----------------------------------------------------------------
	localparam logic [3:0] ITR_ADDR_FIXED = 4'h5;
	localparam int         ITR_ADDR_VAR_W = 3;
	localparam logic [3:0] ITR_BYTE_BITS  = 4'h8;

	// ----------------------------------------------------------------
	// Register index pointer and register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ITR_PTR_RESET  = 8'h00;
	localparam logic [7:0] ITR_PTR_MAX    = 8'hff;
	localparam logic [7:0] ITR_DATA_RESET = 8'h00;
	localparam logic [7:0] ITR_UNDEF_DATA = 8'h00;
	localparam logic [7:0] ITR_IDX_STATUS = 8'h1e;
	localparam logic [7:0] ITR_IDX_CAP    = 8'h1f;
	localparam logic [7:0] ITR_IDX_CURR   = 8'h21;
	localparam logic [7:0] ITR_IDX_FEEDA  = 8'h22;
	localparam logic [7:0] ITR_IDX_FEEDB  = 8'h23;
	localparam logic [7:0] ITR_IDX_TEMP   = 8'h28;

	// ----------------------------------------------------------------
	// Status byte layout
	// ----------------------------------------------------------------
	localparam int ITR_ST_FEEDA_EN = 0;
	localparam int ITR_ST_FEEDB_EN = 1;
	localparam int ITR_ST_ALARM    = 2;
	localparam int ITR_ST_RSVD3    = 3;
	localparam int ITR_ST_CAP_CONN = 4;
	localparam int ITR_ST_INRUSH   = 5;
	localparam int ITR_ST_VOUT_OK  = 6;
	localparam int ITR_ST_RSVD7    = 7;

	// ----------------------------------------------------------------
	// Update timing
	// ----------------------------------------------------------------
	localparam int ITR_CLK_MHZ    = 200;
	localparam int ITR_START_MS   = 300;
	localparam int ITR_PERIOD_MS  = 100;
	localparam int ITR_START_CYC  = ITR_START_MS * 1000 * ITR_CLK_MHZ;
	localparam int ITR_PERIOD_CYC = ITR_PERIOD_MS * 1000 * ITR_CLK_MHZ;

	// ----------------------------------------------------------------
	// Link state machine, Gray along the usual path except the step from ITR_RD_ACK back to ITR_IDLE
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ITR_IDLE     = 3'h0,
		ITR_ADDR     = 3'h1,
		ITR_ADDR_ACK = 3'h3,
		ITR_WR_DATA  = 3'h2,
		ITR_WR_ACK   = 3'h6,
		ITR_RD_DATA  = 3'h7,
		ITR_RD_ACK   = 3'h5
	} itr_state_t;

endpackage : itr_pkg

/* itr_sync.sv */
// Two-stage synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
`default_nettype none

module itr_sync #(
	parameter int         WIDTH = 1,
	parameter logic [0:0] INIT  = 1'h0
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= {WIDTH{INIT}};
			q      <= {WIDTH{INIT}};
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : itr_sync

`default_nettype wire

/* itr_reader.sv */
// Two-wire target exposing telemetry registers through a write-only index pointer
`timescale 1ns/1ps
`default_nettype none

module itr_reader
	import itr_pkg::*;
#(
	parameter int START_CYCLES  = ITR_START_CYC,
	parameter int PERIOD_CYCLES = ITR_PERIOD_CYC
) (
	input  wire logic       MCLK,
	input  wire logic       RESET,
	input  wire logic       SCL,
	input  wire logic       SDA_IN,
	output var  logic       SDA_OUT,
	output var  logic       SDA_OE_N,
	input  wire logic [2:0] ADDR_SEL,
	input  wire logic       UPDATE_STB,
	input  wire logic [7:0] STORAGE_CAP_VOLTAGE,
	input  wire logic [7:0] OUTPUT_CURRENT_VALUE,
	input  wire logic [7:0] FEED_A_VOLTAGE,
	input  wire logic [7:0] FEED_B_VOLTAGE,
	input  wire logic [7:0] AVG_TEMPERATURE,
	input  wire logic       FEED_A_EN,
	input  wire logic       FEED_B_EN,
	input  wire logic       ALARM,
	input  wire logic       CAP_CONNECTED,
	input  wire logic       INRUSH_ON,
	input  wire logic       VOUT_ABOVE,
	output var  logic       UPDATE_REQ,
	output var  logic       LINK_BUSY
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	itr_state_t      state_r;
	logic [3:0]      cnt_r;
	logic [7:0]      shift_r;
	logic [7:0]      tx_r;
	logic [7:0]      ptr_r;
	logic            first_r;
	logic            rw_r;
	logic            ack_r;
	logic [2:0]      adr_r;
	logic            adr_valid_r;
	logic [7:0]      status_r;
	logic [7:0]      cap_r;
	logic [7:0]      curr_r;
	logic [7:0]      feeda_r;
	logic [7:0]      feedb_r;
	logic [7:0]      temp_r;
	logic [31:0]     tmr_r;
	logic            started_r;
	logic            scl_cap_r;
	logic            scl_s;
	logic            sda_s;
	logic [2:0]      adr_s;
	logic            scl_d_r;
	logic            sda_d_r;
	logic            bit_ev;
	logic            scl_fall;
	logic            start_ev;
	logic            stop_ev;
	logic            byte_end;
	logic            addr_hit;
	logic            ptr_load;
	logic            ptr_step;
	logic [7:0]      rd_byte;

	// ----------------------------------------------------------------
	// Register read decode
	// ----------------------------------------------------------------
	function automatic logic [7:0] reg_read(
		input logic [7:0] idx,
		input logic [7:0] st,
		input logic [7:0] cap,
		input logic [7:0] cur,
		input logic [7:0] fa,
		input logic [7:0] fb,
		input logic [7:0] tmp
	);
		logic [7:0] v;
		v = ITR_UNDEF_DATA;
		case (idx)
			ITR_IDX_STATUS: v = st;
			ITR_IDX_CAP:    v = cap;
			ITR_IDX_CURR:   v = cur;
			ITR_IDX_FEEDA:  v = fa;
			ITR_IDX_FEEDB:  v = fb;
			ITR_IDX_TEMP:   v = tmp;
			default:        v = ITR_UNDEF_DATA;
		endcase
		return v;
	endfunction : reg_read

	function automatic logic [7:0] sat_inc(input logic [7:0] p);
		return (p == ITR_PTR_MAX) ? ITR_PTR_MAX : 8'(p + 8'h01);
	endfunction : sat_inc

	// ----------------------------------------------------------------
	// Link clock domain
	// ----------------------------------------------------------------
	// Data bit caught on the link clock's rising edge; it holds until the
	// next rising edge, long after the system side has seen the edge.
	always_ff @(posedge SCL) begin
		scl_cap_r <= SDA_IN;
	end

	// ----------------------------------------------------------------
	// Crossings into the system clock
	// ----------------------------------------------------------------
	itr_sync #(
		.WIDTH (1),
		.INIT  (1'h1)
	) u_sync_scl (
		.clk (MCLK),
		.rst (RESET),
		.d   (SCL),
		.q   (scl_s)
	);

	itr_sync #(
		.WIDTH (1),
		.INIT  (1'h1)
	) u_sync_sda (
		.clk (MCLK),
		.rst (RESET),
		.d   (SDA_IN),
		.q   (sda_s)
	);

	itr_sync #(
		.WIDTH (ITR_ADDR_VAR_W),
		.INIT  (1'h0)
	) u_sync_adr (
		.clk (MCLK),
		.rst (RESET),
		.d   (ADDR_SEL),
		.q   (adr_s)
	);

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// ----------------------------------------------------------------
	// Bus events
	// ----------------------------------------------------------------
	assign bit_ev   = scl_s & ~scl_d_r;
	assign scl_fall = ~scl_s & scl_d_r;
	assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;
	assign byte_end = scl_fall & (cnt_r == ITR_BYTE_BITS);
	assign addr_hit = (shift_r[7:1] == {ITR_ADDR_FIXED, adr_r});

	assign ptr_load = (state_r == ITR_WR_DATA) & byte_end & first_r;
	assign ptr_step = ((state_r == ITR_WR_DATA) & byte_end & ~first_r)
		| ((state_r == ITR_RD_DATA) & scl_fall & (cnt_r == 4'h7));

	assign rd_byte = reg_read(ptr_r, status_r, cap_r, curr_r, feeda_r, feedb_r, temp_r);

	// ----------------------------------------------------------------
	// Address strap
	// ----------------------------------------------------------------
	// Resistor decode arrives as a code; caught at the first start, when the
	// synchroniser has filled, and held so noise cannot move the address.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			adr_r       <= 3'h7;
			adr_valid_r <= 1'b0;
		end else if (!adr_valid_r && start_ev) begin
			adr_r       <= adr_s;
			adr_valid_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Transfer state machine
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			state_r <= ITR_IDLE;
		end else if (start_ev) begin
			state_r <= ITR_ADDR;
		end else if (stop_ev) begin
			state_r <= ITR_IDLE;
		end else begin
			case (state_r)
				ITR_IDLE: begin
					state_r <= ITR_IDLE;
				end
				ITR_ADDR: begin
					if (byte_end) begin
						// Foreign address: back off silently
						state_r <= addr_hit ? ITR_ADDR_ACK : ITR_IDLE;
					end
				end
				ITR_ADDR_ACK: begin
					if (scl_fall) begin
						state_r <= rw_r ? ITR_RD_DATA : ITR_WR_DATA;
					end
				end
				ITR_WR_DATA: begin
					if (byte_end) begin
						state_r <= ITR_WR_ACK;
					end
				end
				ITR_WR_ACK: begin
					if (scl_fall) begin
						state_r <= ITR_WR_DATA;
					end
				end
				ITR_RD_DATA: begin
					if (scl_fall && cnt_r == 4'h7) begin
						state_r <= ITR_RD_ACK;
					end
				end
				ITR_RD_ACK: begin
					if (scl_fall) begin
						state_r <= ack_r ? ITR_RD_DATA : ITR_IDLE;
					end
				end
				default: begin
					state_r <= ITR_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Bit counter and receive shifter
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (RESET || start_ev) begin
			cnt_r <= 4'h0;
		end else if (scl_fall && (state_r == ITR_ADDR_ACK || state_r == ITR_WR_ACK
				|| state_r == ITR_RD_ACK)) begin
			cnt_r <= 4'h0;
		end else if (bit_ev && (state_r == ITR_ADDR || state_r == ITR_WR_DATA)
				&& cnt_r != ITR_BYTE_BITS) begin
			cnt_r <= 4'(cnt_r + 4'h1);
		end else if (scl_fall && state_r == ITR_RD_DATA && cnt_r != 4'h7) begin
			cnt_r <= 4'(cnt_r + 4'h1);
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			shift_r <= 8'h00;
		end else if (bit_ev && (state_r == ITR_ADDR || state_r == ITR_WR_DATA)) begin
			shift_r <= {shift_r[6:0], scl_cap_r};
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			rw_r <= 1'b0;
		end else if (state_r == ITR_ADDR && byte_end) begin
			rw_r <= shift_r[0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET || start_ev) begin
			first_r <= 1'b1;
		end else if (state_r == ITR_WR_DATA && byte_end) begin
			first_r <= 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			ack_r <= 1'b0;
		end else if (state_r == ITR_RD_ACK && bit_ev) begin
			ack_r <= ~scl_cap_r;
		end
	end

	// ----------------------------------------------------------------
	// Index pointer
	// ----------------------------------------------------------------
	// Write bytes past the first are never stored anywhere.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			ptr_r <= ITR_PTR_RESET;
		end else if (ptr_load) begin
			ptr_r <= shift_r;
		end else if (ptr_step) begin
			ptr_r <= sat_inc(ptr_r);
		end
	end

	// ----------------------------------------------------------------
	// Transmit path and data line drive
	// ----------------------------------------------------------------
	// Byte sampled at its first bit so an update mid-byte cannot tear it.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			tx_r <= 8'h00;
		end else if (scl_fall && ((state_r == ITR_ADDR_ACK && rw_r)
				|| (state_r == ITR_RD_ACK && ack_r))) begin
			tx_r <= rd_byte;
		end else if (scl_fall && state_r == ITR_RD_DATA) begin
			tx_r <= {tx_r[6:0], 1'b0};
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET || start_ev || stop_ev) begin
			SDA_OE_N <= 1'b1;
		end else if (scl_fall) begin
			case (state_r)
				ITR_ADDR:     SDA_OE_N <= ~(byte_end & addr_hit);
				ITR_WR_DATA:  SDA_OE_N <= ~byte_end;
				ITR_ADDR_ACK: SDA_OE_N <= rw_r ? rd_byte[7] : 1'b1;
				ITR_RD_DATA:  SDA_OE_N <= (cnt_r == 4'h7) ? 1'b1 : tx_r[6];
				ITR_RD_ACK:   SDA_OE_N <= ack_r ? rd_byte[7] : 1'b1;
				default:      SDA_OE_N <= 1'b1;
			endcase
		end
	end

	// Open drain: the line is only ever pulled low
	always_ff @(posedge MCLK) begin
		SDA_OUT <= 1'b0;
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			LINK_BUSY <= 1'b0;
		end else begin
			LINK_BUSY <= (state_r != ITR_IDLE);
		end
	end

	// ----------------------------------------------------------------
	// Update scheduling
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			tmr_r      <= 32'h0;
			started_r  <= 1'b0;
			UPDATE_REQ <= 1'b0;
		end else if (!started_r) begin
			UPDATE_REQ <= 1'b0;
			if (tmr_r >= 32'(START_CYCLES - 1)) begin
				tmr_r      <= 32'h0;
				started_r  <= 1'b1;
				UPDATE_REQ <= 1'b1;
			end else begin
				tmr_r <= 32'(tmr_r + 32'h1);
			end
		end else if (tmr_r >= 32'(PERIOD_CYCLES - 1)) begin
			tmr_r      <= 32'h0;
			UPDATE_REQ <= 1'b1;
		end else begin
			tmr_r      <= 32'(tmr_r + 32'h1);
			UPDATE_REQ <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Shadow registers
	// ----------------------------------------------------------------
	// All values move in one edge so a reader never sees a mixed set.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			status_r <= ITR_DATA_RESET;
			cap_r    <= ITR_DATA_RESET;
			curr_r   <= ITR_DATA_RESET;
			feeda_r  <= ITR_DATA_RESET;
			feedb_r  <= ITR_DATA_RESET;
			temp_r   <= ITR_DATA_RESET;
		end else if (UPDATE_STB && started_r) begin
			status_r[ITR_ST_FEEDA_EN] <= FEED_A_EN;
			status_r[ITR_ST_FEEDB_EN] <= FEED_B_EN;
			status_r[ITR_ST_ALARM]    <= ALARM;
			status_r[ITR_ST_RSVD3]    <= 1'b0;
			status_r[ITR_ST_CAP_CONN] <= CAP_CONNECTED;
			status_r[ITR_ST_INRUSH]   <= INRUSH_ON;
			status_r[ITR_ST_VOUT_OK]  <= VOUT_ABOVE;
			status_r[ITR_ST_RSVD7]    <= 1'b0;
			cap_r    <= STORAGE_CAP_VOLTAGE;
			curr_r   <= OUTPUT_CURRENT_VALUE;
			feeda_r  <= FEED_A_VOLTAGE;
			feedb_r  <= FEED_B_VOLTAGE;
			temp_r   <= AVG_TEMPERATURE;
		end
	end

endmodule : itr_reader

`default_nettype wire

/* itr_reader_chk.sv */
// Port checker for the telemetry register reader, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module itr_chk
	import itr_pkg::*;
#(
	parameter int START_CYCLES  = ITR_START_CYC,
	parameter int PERIOD_CYCLES = ITR_PERIOD_CYC
) (
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic SCL,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE_N,
	input wire logic UPDATE_REQ,
	input wire logic LINK_BUSY
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	// ----------------------------------------------------------------
	// Counters since release and since the last request
	// ----------------------------------------------------------------
	int since_r;
	int gap_r;
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			since_r <= 0;
			gap_r   <= 0;
		end else begin
			since_r <= since_r + 1;
			gap_r   <= UPDATE_REQ ? 1 : gap_r + 1;
		end
	end

	sequence s_start;
		SCL && $fell(SDA_IN);
	endsequence
	sequence s_scl_fall;
		$fell(SCL);
	endsequence

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_reset_quiet: assert property (disable iff (1'b0)
		RESET |=> SDA_OE_N && !UPDATE_REQ && !LINK_BUSY)
		else $error("outputs active after reset");
	a_req_single: assert property (UPDATE_REQ |=> !UPDATE_REQ)
		else $error("update request longer than one cycle");
	a_req_first: assert property (UPDATE_REQ && since_r <= START_CYCLES + 2
		|-> since_r == START_CYCLES)
		else $error("first update request off its delay");
	a_req_period: assert property (UPDATE_REQ && since_r > START_CYCLES + 2
		|-> gap_r == PERIOD_CYCLES)
		else $error("update request spacing wrong");
	a_busy_start: assert property (s_start |-> ##[1:8] LINK_BUSY)
		else $error("start not taken by the engine");
	a_oe_hold_fall: assert property (s_scl_fall |-> $stable(SDA_OE_N) [*2])
		else $error("data line moved too soon after clock fall");
	a_oe_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL)
		else $error("data line moved while clock high");
	a_oe_needs_busy: assert property (!SDA_OE_N |-> LINK_BUSY)
		else $error("data line pulled while engine idle");
	a_sda_drain: assert property (SDA_OUT == 1'b0)
		else $error("data line output not low");
endmodule : itr_chk

bind itr_reader itr_chk #(
	.START_CYCLES (START_CYCLES),
	.PERIOD_CYCLES(PERIOD_CYCLES)
) itr_chk_i (
	.MCLK(MCLK), .RESET(RESET), .SCL(SCL), .SDA_IN(SDA_IN),
	.SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
	.UPDATE_REQ(UPDATE_REQ), .LINK_BUSY(LINK_BUSY)
);

`default_nettype wire

/* itr_master_model.sv */
// Behavioural two-wire master driving frames at a 64 ns bit time
`timescale 1ns/1ps
`default_nettype none

module itr_master_model (
	output var  logic scl,
	output var  logic sda_oe_n,
	input  wire logic sda
);
	// Clock stands high between frames
	initial begin
		scl      = 1'b1;
		sda_oe_n = 1'b1;
	end

	// Data moves 22 ns after the fall, clear of the target's own turn
	task automatic bit_slot(input logic b, output logic r);
		#22 sda_oe_n = b;
		#10 scl = 1'b1;
		#16 r = sda;
		#16 scl = 1'b0;
	endtask : bit_slot

	task automatic start_frame();
		#16 sda_oe_n = 1'b0;
		#16 scl = 1'b0;
	endtask : start_frame

	task automatic stop_frame();
		#22 sda_oe_n = 1'b0;
		#10 scl = 1'b1;
		#16 sda_oe_n = 1'b1;
		#16;
	endtask : stop_frame

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(d[i], r);
		end
		bit_slot(1'b1, r);
		ack = !r;
	endtask : wr_byte

	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, r);
			d[i] = r;
		end
		bit_slot(!ack, r);
	endtask : rd_byte
endmodule : itr_master_model

`default_nettype wire

/* itr_reader_tb_top.sv */
// Self-checking bench for the telemetry register reader
`timescale 1ns/1ps
`default_nettype none

module itr_reader_tb_top;
	import itr_pkg::*;
	localparam int         START_C  = 50;
	localparam int         PERIOD_C = 100;
	localparam logic [7:0] V_CAP = 8'h3c, V_CUR = 8'h5a, V_FA = 8'ha5, V_FB = 8'hc3, V_TMP = 8'h81;
	localparam logic [5:0] ST    = 6'h2d;
	localparam logic [7:0] EXP_ST  = {1'b0, ST[5:3], 1'b0, ST[2:0]};
	localparam logic [7:0] EXP_ST2 = {1'b0, ~ST[5:3], 1'b0, ~ST[2:0]};
	typedef struct packed { logic [7:0] idx; logic [7:0] exp; } itr_row_t;
	localparam itr_row_t ROWS [9] = '{'{ITR_IDX_STATUS, EXP_ST}, '{ITR_IDX_CAP, V_CAP},
		'{ITR_IDX_CURR, V_CUR}, '{ITR_IDX_FEEDA, V_FA}, '{ITR_IDX_FEEDB, V_FB},
		'{ITR_IDX_TEMP, V_TMP}, '{8'h20, 8'h00}, '{8'h00, 8'h00}, '{8'hff, 8'h00}};

	logic       mclk, reset, update_stb;
	logic [2:0] addr_sel;
	logic [7:0] cap, cur, fa, fb, tmp;
	logic [5:0] st_in;
	logic [6:0] wa;
	int         mismatches, num_checks;
	wire logic  scl, mst_oe_n, sda, sda_out, sda_oe_n, update_req, link_busy;

	// Pull-up on the data line: low when either side pulls
	assign sda = (sda_oe_n ? 1'b1 : sda_out) & mst_oe_n;
	assign wa  = {ITR_ADDR_FIXED, addr_sel};

	itr_reader #(.START_CYCLES(START_C), .PERIOD_CYCLES(PERIOD_C)) itr_reader_i (
		.MCLK(mclk), .RESET(reset), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE_N(sda_oe_n), .ADDR_SEL(addr_sel), .UPDATE_STB(update_stb),
		.STORAGE_CAP_VOLTAGE(cap), .OUTPUT_CURRENT_VALUE(cur), .FEED_A_VOLTAGE(fa),
		.FEED_B_VOLTAGE(fb), .AVG_TEMPERATURE(tmp), .FEED_A_EN(st_in[0]),
		.FEED_B_EN(st_in[1]), .ALARM(st_in[2]), .CAP_CONNECTED(st_in[3]),
		.INRUSH_ON(st_in[4]), .VOUT_ABOVE(st_in[5]), .UPDATE_REQ(update_req),
		.LINK_BUSY(link_busy));
	itr_master_model itr_master_model_i (.scl(scl), .sda_oe_n(mst_oe_n), .sda(sda));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// Compare, report and frame tasks
	// ----------------------------------------------------------------
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk8

	task automatic chk1(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask : chk1

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic wr_frame(input logic [6:0] a, input int n, input logic [23:0] d, output logic ack);
		logic k;
		itr_master_model_i.start_frame();
		itr_master_model_i.wr_byte({a, 1'b0}, ack);
		for (int i = 0; i < n; i++) begin
			itr_master_model_i.wr_byte(d[23-8*i -: 8], k);
		end
		itr_master_model_i.stop_frame();
	endtask : wr_frame

	task automatic rd_frame(input logic [6:0] a, input int n, output logic [23:0] q, output logic ack);
		logic [7:0] b;
		q = 24'h0;
		itr_master_model_i.start_frame();
		itr_master_model_i.wr_byte({a, 1'b1}, ack);
		for (int i = 0; i < n; i++) begin
			itr_master_model_i.rd_byte(i < n - 1, b);
			q[23-8*i -: 8] = b;
		end
		itr_master_model_i.stop_frame();
	endtask : rd_frame

	// Index is loaded by its own write frame, then read in a new frame
	task automatic rd_at(input logic [7:0] idx, input int n, output logic [23:0] q);
		logic ack;
		wr_frame(wa, 1, {idx, 16'h0}, ack);
		chk1("write address ack", 1'b1, ack);
		rd_frame(wa, n, q, ack);
		chk1("read address ack", 1'b1, ack);
	endtask : rd_at

	task automatic strobe();
		@(posedge mclk);
		#1 update_stb = 1'b1;
		@(posedge mclk);
		#1 update_stb = 1'b0;
	endtask : strobe

	task automatic wait_req();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (update_req !== 1'b1 && n < START_C + PERIOD_C);
		if (update_req !== 1'b1) begin
			mismatches++;
			$display("unexpected update request: expected 1 seen %b", update_req);
			wrap_up();
		end
	endtask : wait_req

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [23:0] q;
		logic        ack;
		mismatches = 0;
		num_checks = 0;
		{reset, update_stb, addr_sel, st_in} = {1'b1, 1'b0, 3'h3, ST};
		{cap, cur, fa, fb, tmp} = {V_CAP, V_CUR, V_FA, V_FB, V_TMP};
		repeat (8) @(posedge mclk);
		#1 reset = 1'b0;
		repeat (12) @(posedge mclk);
		strobe();
		rd_at(ITR_IDX_FEEDA, 1, q);
		chk8("data before first update", ITR_DATA_RESET, q[23:16]);
		wait_req();
		strobe();
		foreach (ROWS[i]) begin
			rd_at(ROWS[i].idx, 1, q);
			chk8("register data", ROWS[i].exp, q[23:16]);
			$display("row %0d index %h done", i, ROWS[i].idx);
		end
		rd_at(ITR_IDX_FEEDA, 3, q);
		chk8("burst byte 0", V_FA, q[23:16]);
		chk8("burst byte 1", V_FB, q[15:8]);
		chk8("burst byte 2", ITR_UNDEF_DATA, q[7:0]);
		$display("burst read done");
		wr_frame(wa, 3, {ITR_IDX_CAP, 16'h0}, ack);
		rd_frame(wa, 2, q, ack);
		chk8("advanced pointer byte 0", V_CUR, q[23:16]);
		chk8("advanced pointer byte 1", V_FA, q[15:8]);
		rd_at(ITR_IDX_CAP, 1, q);
		chk8("register after write", V_CAP, q[23:16]);
		wr_frame(wa ^ 7'h01, 1, {ITR_IDX_TEMP, 16'h0}, ack);
		chk1("foreign write ack", 1'b0, ack);
		rd_frame(wa ^ 7'h01, 1, q, ack);
		chk1("foreign read ack", 1'b0, ack);
		rd_frame(wa, 1, q, ack);
		chk8("pointer after foreign frames", ITR_UNDEF_DATA, q[23:16]);
		$display("write advance and foreign address done");
		wr_frame(wa, 3, {8'hfe, 16'h0}, ack);
		rd_frame(wa, 2, q, ack);
		chk8("saturated pointer data", 8'h00, q[23:16] | q[15:8]);
		// A wrapped pointer would reach the status byte within this burst
		itr_master_model_i.start_frame();
		itr_master_model_i.wr_byte({wa, 1'b1}, ack);
		chk1("held pointer read ack", 1'b1, ack);
		q = 24'h0;
		for (int i = 0; i < 32; i++) begin
			itr_master_model_i.rd_byte(i < 31, q[7:0]);
			q[23:16] = q[23:16] | q[7:0];
		end
		itr_master_model_i.stop_frame();
		chk8("pointer held at top", 8'h00, q[23:16]);
		@(posedge mclk);
		#1 {cap, st_in} = {~V_CAP, ~ST};
		strobe();
		rd_at(ITR_IDX_STATUS, 2, q);
		chk8("status after update", EXP_ST2, q[23:16]);
		chk8("cap after update", ~V_CAP, q[15:8]);
		$display("saturation and second update done");
		for (int c = 0; c < 8; c++) begin
			@(posedge mclk);
			#1 {reset, addr_sel} = {1'b1, 3'(c)};
			repeat (4) @(posedge mclk);
			#1 reset = 1'b0;
			repeat (12) @(posedge mclk);
			wr_frame({4'h4, addr_sel}, 0, 24'h0, ack);
			chk1("wrong fixed nibble ack", 1'b0, ack);
			rd_at(ITR_IDX_FEEDA, 1, q);
			chk8("data after reset", ITR_DATA_RESET, q[23:16]);
		end
		$display("address select and reset done");
		wrap_up();
	end
endmodule : itr_reader_tb_top

`default_nettype wire
